// ### pmtr_core_model.sv
// Core-side model that paces instruction cycles and steps the program counter.
`timescale 1ns/1ps
module pmtr_core_model
   import pmtr_pkg::*;
(
   input wire logic clk_sys, // Clock.
   input wire logic sys_rst, // Reset.
   output logic instr_cycle_en, // One pulse every four clocks.
   output logic [pmtr_pkg::PMTR_ADDR_W-1:0] pc_next // Next fetch address.
);
   import pmtr_pkg::*;
   logic [1:0] phase;
   // ====
   // Four clocks make one instruction cycle; the counter restarts at word zero.
   // No interrupt routine runs here, so table reads never interleave.
   always @(negedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phase <= 2'h0;
         instr_cycle_en <= 1'b0;
         pc_next <= PMTR_RESET_VECTOR;
      end else begin
         phase <= phase + 2'h1;
         instr_cycle_en <= (phase == 2'h3);
         if (instr_cycle_en) begin
            pc_next <= pc_next + 14'h1;
         end
      end
   end
endmodule

// ### pmtr_flash_array.sv
// Flash word array with a registered read port and a word-wide programming write port.
`timescale 1ns/1ps
module pmtr_flash_array
   import pmtr_pkg::*;
(
   input wire logic clk_sys, // System clock.
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] rd_addr, // Read word address.
   output logic [pmtr_pkg::PMTR_WORD_W-1:0] rd_data, // Registered read word.
   input wire logic wr_en, // Programming write strobe.
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] wr_addr, // Programming word address.
   input wire logic [pmtr_pkg::PMTR_WORD_W-1:0] wr_data // Programming word.
);
   // ==========================================================
   // Storage sized for the larger variant; the smaller one uses the low half.
   logic [PMTR_WORD_W-1:0] mem [0:(1<<PMTR_ADDR_W)-1]; // [RULE1]

   // Registered read; no reset because array contents are non-volatile.
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ### pmtr_pkg.sv
// Package with the sizes, encodings and timing counts of the program memory table-read path.
package pmtr_pkg;
   // ==========================================================
   // Memory geometry.
   localparam int PMTR_WORD_W = 16;
   localparam int PMTR_ADDR_W = 14;
   localparam logic [PMTR_ADDR_W-1:0] PMTR_WORDS_SMALL = 14'h2000;
   localparam logic [PMTR_ADDR_W-1:0] PMTR_WORDS_LARGE = 14'h3FFF;
   localparam int PMTR_BANK_BIT = 13;
   localparam logic [PMTR_ADDR_W-1:0] PMTR_RESET_VECTOR = 14'h0000;
   localparam int PMTR_DM_ADDR_W = 8;
   localparam int PMTR_SECTOR_W = 3;
   localparam logic [PMTR_SECTOR_W-1:0] PMTR_SECTOR0 = 3'h0;
   // ==========================================================
   // Timing: a table read occupies two instruction cycles.
   localparam logic [1:0] PMTR_TABLE_CYCLES = 2'h2;
   // ==========================================================
   // Access states.
   typedef enum logic [1:0] {
      PMTR_IDLE,
      PMTR_FETCH,
      PMTR_WRITE
   } pmtr_state_t;
endpackage

// ### pmtr_table_read.sv
// Program memory access path serving instruction fetches and table reads.
//
// Operation
// [RULE1] 16-bit words, 8K or 16K, two banks.
// [RULE2] Reset starts fetching at word zero.
// [RULE3] Pointer pair forms full table address.
// [RULE4] Low byte goes to operand register.
// [RULE5] High byte replaces latch content.
// [RULE6] Basic form targets sector 0 only.
// [RULE7] Table instructions take two cycles.
// [RULE8] Latch readable and writable by software.
// [RULE9] Software masks interrupts around shared reads.
// [RULE10] High pointer pages, low pointer offsets.
// [RULE11] Programming uses data line plus clock.
// [RULE12] Debug pins keep programming role on emulator.
// [RULE13] Excess pointer bits ignored, address wraps.
`timescale 1ns/1ps
module pmtr_table_read
   import pmtr_pkg::*;
(
   input wire logic clk_sys, // System clock, 25 MHz.
   input wire logic sys_rst, // Asynchronous reset, active high.
   input wire logic large_variant, // High selects the 16K-word variant.
   input wire logic emulation_chip, // High on the emulation variant.
   input wire logic instr_cycle_en, // One-cycle pulse per instruction cycle.
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] pc_next, // Next program counter from core.
   output logic [pmtr_pkg::PMTR_ADDR_W-1:0] fetch_addr, // Current fetch address.
   output logic [pmtr_pkg::PMTR_WORD_W-1:0] instr_word, // Fetched instruction word.
   output logic fetch_stall, // High while a table read holds the fetch.
   input wire logic [7:0] tbl_ptr_low, // Table pointer low byte.
   input wire logic [7:0] tbl_ptr_high, // Table pointer high byte.
   input wire logic tbl_req, // Basic table read request, one cycle.
   input wire logic ext_tbl_req, // Extended table read request, one cycle.
   input wire logic [pmtr_pkg::PMTR_SECTOR_W-1:0] dst_sector, // Destination sector.
   input wire logic [pmtr_pkg::PMTR_DM_ADDR_W-1:0] dst_addr, // Destination address.
   output logic dm_wr, // Data memory write strobe, one cycle.
   output logic [pmtr_pkg::PMTR_SECTOR_W-1:0] dm_sector, // Data memory write sector.
   output logic [pmtr_pkg::PMTR_DM_ADDR_W-1:0] dm_addr, // Data memory write address.
   output logic [7:0] dm_data, // Data memory write byte.
   output logic tbl_done, // Table read complete, one cycle.
   output logic tbl_reject, // Basic read aimed outside sector 0, one cycle.
   input wire logic latch_wr, // Software write of the high-byte latch.
   input wire logic [7:0] latch_wdata, // Byte written to the latch.
   output logic [7:0] table_high_byte_latch, // High-byte latch content.
   input wire logic prog_mode, // High while an external programmer is attached.
   input wire logic prog_serial_clock, // Programming clock from programmer.
   input wire logic prog_serial_data_in, // Programming data pin level.
   output logic prog_serial_data_out, // Programming data driven by device.
   output logic prog_serial_data_oe, // High while device drives the data pin.
   input wire logic debug_serial_clock, // Debug clock on the emulator.
   input wire logic debug_serial_data_in, // Debug data pin level.
   output logic debug_serial_data_out, // Debug data driven by device.
   output logic debug_serial_data_oe, // High while device drives debug data.
   output logic prog_wr_en, // Programming word write strobe.
   output logic [pmtr_pkg::PMTR_ADDR_W-1:0] prog_wr_addr, // Programming word address.
   output logic [pmtr_pkg::PMTR_WORD_W-1:0] prog_wr_data // Programming word.
);
   import pmtr_pkg::*;

   // ==========================================================
   // Declarations.
   pmtr_state_t state_ff, nxt_state;
   logic [PMTR_ADDR_W-1:0] fetch_addr_ff, nxt_fetch_addr;
   logic [PMTR_ADDR_W-1:0] tbl_addr_ff, nxt_tbl_addr;
   logic [PMTR_SECTOR_W-1:0] sect_ff, nxt_sect;
   logic [PMTR_DM_ADDR_W-1:0] daddr_ff, nxt_daddr;
   logic [7:0] latch_ff, nxt_latch;
   logic dm_wr_ff, nxt_dm_wr;
   logic [7:0] dm_data_ff, nxt_dm_data;
   logic done_ff, nxt_done;
   logic rej_ff, nxt_rej;
   logic [PMTR_ADDR_W-1:0] arr_addr;
   logic [PMTR_WORD_W-1:0] arr_data;
   logic [PMTR_ADDR_W-1:0] ptr_full;
   logic [PMTR_ADDR_W-1:0] addr_mask;
   logic accept;
   logic ser_clk, ser_din, ser_clk_d_ff, nxt_ser_clk_d;
   logic [PMTR_WORD_W+PMTR_ADDR_W-1:0] shift_ff, nxt_shift;
   logic [4:0] bit_cnt_ff, nxt_bit_cnt;
   logic pwr_ff, nxt_pwr;

   // ==========================================================
   // Address forming and variant masking.
   // The smaller part has no bank bit, so pointer bits 13 and above drop away.
   assign addr_mask = large_variant ? PMTR_WORDS_LARGE : (PMTR_WORDS_SMALL - 14'h0001); // [RULE1]
   assign ptr_full = {tbl_ptr_high[5:0], tbl_ptr_low} & addr_mask; // [RULE3] [RULE10] [RULE13]

   // A basic read aimed outside sector 0 is refused rather than misdirected.
   assign accept = instr_cycle_en && ((tbl_req && dst_sector == PMTR_SECTOR0) || ext_tbl_req); // [RULE6]

   // The array port is shared; the table read holds it until its write cycle.
   // Releasing it after the fetch would hand the write the instruction word instead.
   assign arr_addr = (state_ff != PMTR_IDLE) ? tbl_addr_ff : fetch_addr_ff; // [RULE3]

   pmtr_flash_array u_array (
      .clk_sys(clk_sys),
      .rd_addr(arr_addr),
      .rd_data(arr_data),
      .wr_en(pwr_ff),
      .wr_addr(prog_wr_addr),
      .wr_data(prog_wr_data)
   );

   // ==========================================================
   // Table-read sequencer, next-state logic.
   always_comb begin
      nxt_state = state_ff;
      nxt_fetch_addr = fetch_addr_ff;
      nxt_tbl_addr = tbl_addr_ff;
      nxt_sect = sect_ff;
      nxt_daddr = daddr_ff;
      nxt_latch = latch_ff;
      nxt_dm_wr = 1'b0;
      nxt_dm_data = dm_data_ff;
      nxt_done = 1'b0;
      nxt_rej = 1'b0;
      if (latch_wr) begin
         nxt_latch = latch_wdata; // [RULE8]
      end
      case (state_ff)
         PMTR_IDLE: begin
            if (instr_cycle_en) begin
               nxt_fetch_addr = pc_next & addr_mask;
            end
            if (accept) begin
               nxt_tbl_addr = ptr_full; // [RULE3]
               nxt_sect = ext_tbl_req ? dst_sector : PMTR_SECTOR0; // [RULE6]
               nxt_daddr = dst_addr;
               nxt_state = PMTR_FETCH; // [RULE7]
            end else if (instr_cycle_en && tbl_req) begin
               nxt_rej = 1'b1; // [RULE6]
            end
         end
         PMTR_FETCH: begin
            // The array answers one clock later, so wait for the data.
            if (instr_cycle_en) begin
               nxt_state = PMTR_WRITE;
            end
         end
         PMTR_WRITE: begin
            // Second instruction cycle: both result bytes land together.
            if (instr_cycle_en) begin
               nxt_dm_wr = 1'b1;
               nxt_dm_data = arr_data[7:0]; // [RULE4]
               nxt_latch = arr_data[15:8]; // [RULE5]
               nxt_done = 1'b1; // [RULE7]
               nxt_state = PMTR_IDLE;
            end
         end
         default: begin
            nxt_state = PMTR_IDLE;
         end
      endcase
   end

   // Table-read sequencer registers; reset points fetching at the vector.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= PMTR_IDLE;
         fetch_addr_ff <= PMTR_RESET_VECTOR; // [RULE2]
         tbl_addr_ff <= PMTR_RESET_VECTOR;
         sect_ff <= PMTR_SECTOR0;
         daddr_ff <= 8'h00;
         latch_ff <= 8'h00;
         dm_wr_ff <= 1'b0;
         dm_data_ff <= 8'h00;
         done_ff <= 1'b0;
         rej_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         fetch_addr_ff <= nxt_fetch_addr;
         tbl_addr_ff <= nxt_tbl_addr;
         sect_ff <= nxt_sect;
         daddr_ff <= nxt_daddr;
         latch_ff <= nxt_latch;
         dm_wr_ff <= nxt_dm_wr;
         dm_data_ff <= nxt_dm_data;
         done_ff <= nxt_done;
         rej_ff <= nxt_rej;
      end
   end

   assign fetch_addr = fetch_addr_ff;
   assign instr_word = arr_data;
   assign fetch_stall = (state_ff != PMTR_IDLE);
   assign dm_wr = dm_wr_ff;
   assign dm_sector = sect_ff;
   assign dm_addr = daddr_ff;
   assign dm_data = dm_data_ff;
   assign tbl_done = done_ff;
   assign tbl_reject = rej_ff;
   assign table_high_byte_latch = latch_ff;

   // ==========================================================
   // Programming pins: on the emulator the debug pins carry the same link.
   // The device never drives either data pin, so the programmer owns the line.
   assign ser_clk = emulation_chip ? debug_serial_clock : prog_serial_clock; // [RULE12]
   assign ser_din = emulation_chip ? debug_serial_data_in : prog_serial_data_in; // [RULE12]
   assign prog_serial_data_out = 1'b0;
   assign prog_serial_data_oe = 1'b0; // [RULE11]
   assign debug_serial_data_out = 1'b0;
   assign debug_serial_data_oe = 1'b0; // [RULE11]

   // Minimal serial load: address then data, MSB first, one bit per rising clock.
   // The serial protocol itself is not defined here; this only lands whole words.
   always_comb begin
      nxt_ser_clk_d = ser_clk;
      nxt_shift = shift_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_pwr = 1'b0;
      if (!prog_mode) begin
         nxt_bit_cnt = 5'h00;
      end else if (ser_clk && !ser_clk_d_ff) begin
         nxt_shift = {shift_ff[PMTR_WORD_W+PMTR_ADDR_W-2:0], ser_din}; // [RULE11]
         if (bit_cnt_ff == 5'h1D) begin
            nxt_bit_cnt = 5'h00;
            nxt_pwr = 1'b1;
         end else begin
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ser_clk_d_ff <= 1'b0;
         shift_ff <= 30'h00000000;
         bit_cnt_ff <= 5'h00;
         pwr_ff <= 1'b0;
      end else begin
         ser_clk_d_ff <= nxt_ser_clk_d;
         shift_ff <= nxt_shift;
         bit_cnt_ff <= nxt_bit_cnt;
         pwr_ff <= nxt_pwr;
      end
   end

   assign prog_wr_en = pwr_ff;
   assign prog_wr_addr = shift_ff[PMTR_WORD_W+PMTR_ADDR_W-1:PMTR_WORD_W] & addr_mask;
   assign prog_wr_data = shift_ff[PMTR_WORD_W-1:0];
endmodule

// ### pmtr_table_read_checker.sv
// Concurrent checks on the table-read path, bound to its top module.
`timescale 1ns/1ps
module pmtr_table_read_checker
   import pmtr_pkg::*;
(
   input wire logic clk_sys, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic instr_cycle_en, // Cycle pulse.
   input wire logic tbl_req, // Basic read.
   input wire logic ext_tbl_req, // Extended read.
   input wire logic [pmtr_pkg::PMTR_SECTOR_W-1:0] dst_sector, // Sector.
   input wire logic fetch_stall, // Stall.
   input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] fetch_addr, // Fetch address.
   input wire logic dm_wr, // Write strobe.
   input wire logic tbl_done, // Done.
   input wire logic tbl_reject, // Refusal.
   input wire logic latch_wr, // Latch write.
   input wire logic [7:0] table_high_byte_latch, // Latch.
   input wire logic prog_mode, // Programming.
   input wire logic prog_wr_en, // Array write.
   input wire logic prog_serial_data_oe, // Pin enable.
   input wire logic debug_serial_data_oe // Pin enable.
);
   import pmtr_pkg::*;
   logic [1:0] cyc_ff;
   logic [1:0] nxt_cyc;
   logic take;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ====
   // Counts instruction cycles spent stalled, so a read ending early or late shows.
   assign take = instr_cycle_en && !fetch_stall
      && (ext_tbl_req || (tbl_req && dst_sector == PMTR_SECTOR0));
   always_comb begin
      nxt_cyc = cyc_ff;
      if (!fetch_stall) begin
         nxt_cyc = 2'h0;
      end else if (instr_cycle_en) begin
         nxt_cyc = cyc_ff + 2'h1;
      end
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cyc_ff <= 2'h0;
      end else begin
         cyc_ff <= nxt_cyc;
      end
   end
   // ====
   // Properties.
   property p_reset_vec; $fell(sys_rst) |-> fetch_addr == PMTR_RESET_VECTOR; endproperty
   property p_take; take |=> fetch_stall && !dm_wr; endproperty
   property p_two_cycles; dm_wr |-> !fetch_stall && cyc_ff == PMTR_TABLE_CYCLES; endproperty
   property p_done; dm_wr |-> tbl_done && !tbl_reject; endproperty
   property p_latch_src; $changed(table_high_byte_latch) |-> dm_wr || $past(latch_wr); endproperty
   property p_reject;
      instr_cycle_en && !fetch_stall && tbl_req && !ext_tbl_req && dst_sector != PMTR_SECTOR0
      |=> tbl_reject && !fetch_stall;
   endproperty
   property p_no_drive; !prog_serial_data_oe && !debug_serial_data_oe; endproperty
   property p_prog; prog_wr_en |-> prog_mode; endproperty
   property p_stall_hold; fetch_stall |=> $stable(fetch_addr); endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("fetch not at vector");
   a_take: assert property (p_take) else $error("read not taken");
   a_two_cycles: assert property (p_two_cycles) else $error("read length");
   a_done: assert property (p_done) else $error("done not with write");
   a_latch_src: assert property (p_latch_src) else $error("latch changed alone");
   a_reject: assert property (p_reject) else $error("basic read not refused");
   a_no_drive: assert property (p_no_drive) else $error("pin driven");
   a_prog: assert property (p_prog) else $error("array write outside programming");
   a_stall_hold: assert property (p_stall_hold) else $error("fetch moved in stall");
   c_read: cover property (dm_wr);
   c_reject: cover property (tbl_reject);
   c_prog: cover property (prog_wr_en);
endmodule

bind pmtr_table_read pmtr_table_read_checker i_chk (.clk_sys, .sys_rst, .instr_cycle_en,
   .tbl_req, .ext_tbl_req, .dst_sector, .fetch_stall, .fetch_addr, .dm_wr, .tbl_done,
   .tbl_reject, .latch_wr, .table_high_byte_latch, .prog_mode, .prog_wr_en,
   .prog_serial_data_oe, .debug_serial_data_oe);

// ### pmtr_table_read_tb.sv
// Self-checking testbench for the program memory table-read path.
`timescale 1ns/1ps
module pmtr_table_read_tb;
   import pmtr_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, large_variant = 1'b1, emulation_chip = 1'b0;
   logic tbl_req = 1'b0, ext_tbl_req = 1'b0, latch_wr = 1'b0, prog_mode = 1'b0;
   logic prog_serial_clock = 1'b0, prog_serial_data_in = 1'b0;
   logic debug_serial_clock = 1'b0, debug_serial_data_in = 1'b0;
   logic [7:0] tbl_ptr_low = 8'h0, tbl_ptr_high = 8'h0, dst_addr = 8'h0, latch_wdata = 8'h0;
   logic [2:0] dst_sector = 3'h0, dm_sector;
   logic instr_cycle_en, fetch_stall, dm_wr, tbl_done, tbl_reject, prog_wr_en;
   logic prog_serial_data_out, prog_serial_data_oe, debug_serial_data_out, debug_serial_data_oe;
   logic [13:0] pc_next, fetch_addr, prog_wr_addr;
   logic [15:0] instr_word, prog_wr_data, w0, w1, w2;
   logic [7:0] dm_addr, dm_data, table_high_byte_latch;
   int seed = 32'h0f84026a;
   int mismatches = 0, total_checks = 0;
   logic [27:0] notes[$];
   pmtr_table_read i_pmtr_table_read (.clk_sys, .sys_rst, .large_variant, .emulation_chip,
      .instr_cycle_en, .pc_next, .fetch_addr, .instr_word, .fetch_stall, .tbl_ptr_low,
      .tbl_ptr_high, .tbl_req, .ext_tbl_req, .dst_sector, .dst_addr, .dm_wr, .dm_sector,
      .dm_addr, .dm_data, .tbl_done, .tbl_reject, .latch_wr, .latch_wdata,
      .table_high_byte_latch, .prog_mode, .prog_serial_clock, .prog_serial_data_in,
      .prog_serial_data_out, .prog_serial_data_oe, .debug_serial_clock, .debug_serial_data_in,
      .debug_serial_data_out, .debug_serial_data_oe, .prog_wr_en, .prog_wr_addr, .prog_wr_data);
   pmtr_core_model i_pmtr_core_model (.clk_sys, .sys_rst, .instr_cycle_en, .pc_next);
   // ====
   // Clock and shared helpers.
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic check(input string what, input logic [27:0] seen, input logic [27:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Shifts address then data, MSB first, on the programming or debug clock.
   task automatic load(input logic [13:0] a, input logic [15:0] d, input logic emu);
      logic [29:0] bits;
      bits = {a, d};
      emulation_chip = emu;
      prog_mode = 1'b1;
      for (int i = 29; i >= 0; i--) begin
         @(negedge clk_sys);
         prog_serial_data_in = bits[i];
         debug_serial_data_in = bits[i];
         repeat (2) @(negedge clk_sys);
         prog_serial_clock = !emu;
         debug_serial_clock = emu;
         @(negedge clk_sys);
         check("prog strobe", prog_wr_en, (i == 0) ? 28'h1 : 28'h0);
         if (i == 0) begin
            check("prog address", prog_wr_addr, a);
            check("prog data", prog_wr_data, d);
         end
         @(negedge clk_sys);
         prog_serial_clock = 1'b0;
         debug_serial_clock = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      prog_mode = 1'b0;
      emulation_chip = 1'b0;
   endtask
   // Holds a request until an idle cycle edge takes it, then waits for its result.
   task automatic tread(input logic [7:0] hi, lo, input logic [2:0] sec, input logic ext,
      input logic [15:0] w);
      int n;
      @(negedge clk_sys);
      tbl_ptr_high = hi;
      tbl_ptr_low = lo;
      dst_sector = sec;
      dst_addr = 8'($random(seed));
      ext_tbl_req = ext;
      tbl_req = !ext || seed[0];
      notes.push_back((!ext && sec != 3'h0) ? {1'b1, 27'h0} : {1'b0, sec, w[15:8], dst_addr, w[7:0]});
      // Settled outputs show whether the request was taken or refused.
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (fetch_stall !== 1'b1 && tbl_reject !== 1'b1 && n < 40);
      tbl_req = 1'b0;
      ext_tbl_req = 1'b0;
      while (notes.size() > 0 && n < 80) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 80) begin
         mismatches++;
         results();
      end
   endtask
   // ====
   // Result watcher: each write or refusal consumes the oldest note.
   always @(negedge clk_sys) begin
      if (dm_wr === 1'b1 || tbl_reject === 1'b1) begin
         check("table result", {tbl_reject, dm_wr ? {dm_sector, table_high_byte_latch, dm_addr,
            dm_data} : 27'h0}, notes.size() > 0 ? notes.pop_front() : 28'hFFFFFFF);
      end
   end
   // ====
   // Main sequence.
   initial begin
      w0 = 16'($random(seed));
      w1 = 16'($random(seed));
      w2 = 16'($random(seed));
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      load(14'h0000, w0, 1'b0);
      load(14'h1F06, w1, 1'b0);
      load(14'h3F05, w2, 1'b1);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      check("fetch address", fetch_addr, 28'h0);
      @(negedge clk_sys);
      check("reset word", instr_word, w0);
      $display("test reset vector done");
      latch_wr = 1'b1;
      latch_wdata = 8'($random(seed));
      @(negedge clk_sys);
      latch_wr = 1'b0;
      check("latch", table_high_byte_latch, latch_wdata);
      $display("test latch write done");
      for (int s = 0; s < 8; s++) begin
         tread(8'h1F, 8'h06, 3'(s), 1'b0, w1);
         tread(8'h1F, 8'h06, 3'(s), 1'b1, w1);
      end
      $display("test sector sweep done");
      tread(8'hFF, 8'h05, 3'h0, 1'b0, w2);
      tread(8'hC0, 8'h00, 3'h2, 1'b1, w0);
      large_variant = 1'b0;
      tread(8'h3F, 8'h06, 3'h0, 1'b0, w1);
      $display("test address wrap done");
      results();
   end
endmodule
